// ==== include/rsd_pkg.sv ====
/*
 * package of the receiver status display registers: offsets, field
 * positions, reset values and the status carrier structs.
 * assumes the register interface hands over an 8-bit address and strobes.
 */
// Operation
// - regulator setting shown in upper nibble
// - reset and defaults give all-ones regulator
// - bit 2 shows general timer running
// - bit 1 shows no-response timer running
// - bit 0 shows mask-receive timer running
// - AM peak in bits 7..4, larger wins
// - PM peak in bits 3..0, larger wins
// - peaks cleared at message start, clear command
// - strength code is 4-bit logarithmic level
// - strength and gain registers reset to zero
// - selected channel strength used internally
// - AM gain cut in bits 7..4
// - PM gain cut in bits 3..0
// - two reserved read-only slots follow
// - regulator source from manual or automatic
package rsd_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] RSD_OFS_REG_TIMER = 8'h2B;
    localparam logic [7:0] RSD_OFS_PEAKS = 8'h2C;
    localparam logic [7:0] RSD_OFS_GAIN = 8'h2D;
    localparam logic [7:0] RSD_OFS_RSVD_A = 8'h2E;
    localparam logic [7:0] RSD_OFS_RSVD_B = 8'h2F;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int RSD_REG_LSB = 4;
    localparam int RSD_GPT_BIT = 2;
    localparam int RSD_NRT_BIT = 1;
    localparam int RSD_MRT_BIT = 0;
    localparam logic [3:0] RSD_REG_RESET = 4'hF;
    localparam logic [3:0] RSD_LEVEL_RESET = 4'h0;
    localparam logic [7:0] RSD_ZERO_BYTE = 8'h00;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic gptRunning; // general purpose timer counting
        logic nrtRunning; // no-response timer counting
        logic mrtRunning; // mask-receive timer counting
    } rsd_timers_t;
    typedef struct packed {
        logic [3:0] am; // am channel value
        logic [3:0] pm; // pm channel value
    } rsd_pair_t;
endpackage

// ==== hdl/rsd_status_regs.sv ====
/*
 * receiver status display registers: regulator/timer, peak strength,
 * gain cut, two reserved slots. read-only register port.
 * assumes all status inputs are synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rsd_status_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic setDefaults, // restore-defaults command pulse
    input wire logic regSourceManual, // regulator source select
    input wire logic [3:0] regManualLevel, // written level field
    input wire logic [3:0] regAutoLevel, // adjust-regulators result
    input wire rsd_pkg::rsd_timers_t timers, // timer running levels
    input wire logic measValid, // new strength sample pulse
    input wire rsd_pkg::rsd_pair_t measLevel, // sampled strength codes
    input wire logic msgStart, // transponder message begins
    input wire logic peakClear, // clear-peak command pulse
    input wire rsd_pkg::rsd_pair_t gainCut, // total second-stage cut
    input wire logic channelPm, // selected channel, 1 = pm
    input wire logic rdEn, // read strobe
    input wire logic wrEn, // write strobe, ignored
    input wire logic [7:0] addr, // register address
    output logic [7:0] rdData, // read data, registered
    output logic [3:0] selLevel // selected channel peak
);
    import rsd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] regLevel_reg, regLevel_next; // applied regulator code
    rsd_timers_t timers_reg, timers_next; // timer status copy
    rsd_pair_t peak_reg, peak_next; // peak strength
    rsd_pair_t gain_reg, gain_next; // gain cut copy
    logic [7:0] rdData_reg, rdData_next; // read data
    logic [3:0] sel_reg, sel_next; // selected channel level

    // larger of two codes
    function automatic logic [3:0] maxCode(input logic [3:0] a, input logic [3:0] b);
        maxCode = (a > b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        regLevel_next = regSourceManual ? regManualLevel : regAutoLevel;
        timers_next = timers;
        peak_next = peak_reg;
        gain_next = gainCut;
        if (msgStart || peakClear) begin
            peak_next = '{am: RSD_LEVEL_RESET, pm: RSD_LEVEL_RESET};
        end else if (measValid) begin
            peak_next.am = maxCode(peak_reg.am, measLevel.am);
            peak_next.pm = maxCode(peak_reg.pm, measLevel.pm);
        end
        if (setDefaults) begin
            regLevel_next = RSD_REG_RESET;
            peak_next = '{am: RSD_LEVEL_RESET, pm: RSD_LEVEL_RESET};
            gain_next = '{am: RSD_LEVEL_RESET, pm: RSD_LEVEL_RESET};
        end
        sel_next = channelPm ? peak_reg.pm : peak_reg.am;
        rdData_next = rdData_reg;
        if (rdEn) begin
            case (addr)
                RSD_OFS_REG_TIMER: begin
                    rdData_next = RSD_ZERO_BYTE;
                    rdData_next[RSD_REG_LSB +: 4] = regLevel_reg;
                    rdData_next[RSD_GPT_BIT] = timers_reg.gptRunning;
                    rdData_next[RSD_NRT_BIT] = timers_reg.nrtRunning;
                    rdData_next[RSD_MRT_BIT] = timers_reg.mrtRunning;
                end
                RSD_OFS_PEAKS: rdData_next = peak_reg;
                RSD_OFS_GAIN: rdData_next = gain_reg;
                RSD_OFS_RSVD_A, RSD_OFS_RSVD_B: rdData_next = RSD_ZERO_BYTE;
                default: rdData_next = RSD_ZERO_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers; writes never reach them
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regLevel_reg <= RSD_REG_RESET;
            timers_reg <= '0;
            peak_reg <= '0;
            gain_reg <= '0;
            rdData_reg <= RSD_ZERO_BYTE;
            sel_reg <= RSD_LEVEL_RESET;
        end else begin
            regLevel_reg <= regLevel_next;
            timers_reg <= timers_next;
            peak_reg <= peak_next;
            gain_reg <= gain_next;
            rdData_reg <= rdData_next;
            sel_reg <= sel_next;
        end
    end

    assign rdData = rdData_reg;
    assign selLevel = sel_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence clearSeen;
        (msgStart || peakClear || setDefaults);
    endsequence
    sequence peaksZero;
        (peak_reg == '0);
    endsequence

    peak_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
        clearSeen |=> peaksZero) else $error("peaks not cleared");
    // a named sequence cannot be negated, so the idle case spells out the clear sources
    peak_grow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!msgStart && !peakClear && !setDefaults && !measValid) |=> $stable(peak_reg))
        else $error("peak changed idle");
    peak_max_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (measValid && !msgStart && !peakClear && !setDefaults) |=>
        (peak_reg.pm >= $past(measLevel.pm)) && (peak_reg.am >= $past(measLevel.am)))
        else $error("peak below sample");
    reg_src_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!setDefaults && regSourceManual) |=> regLevel_reg == $past(regManualLevel))
        else $error("manual level not applied");
    reg_auto_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (!setDefaults && !regSourceManual) |=> regLevel_reg == $past(regAutoLevel))
        else $error("auto level not applied");
    reg_default_a: assert property (@(posedge core_clk) disable iff (!rstn)
        setDefaults |=> regLevel_reg == RSD_REG_RESET) else $error("regulator default");
    read_timer_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (rdEn && addr == RSD_OFS_REG_TIMER) |=>
        rdData[RSD_GPT_BIT] == $past(timers_reg.gptRunning) && rdData[3] == 1'b0)
        else $error("timer bit readback");
    read_rsvd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (rdEn && (addr == RSD_OFS_RSVD_A || addr == RSD_OFS_RSVD_B)) |=> rdData == '0)
        else $error("reserved not zero");
    gain_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !setDefaults ##1 !setDefaults |=> gain_reg == $past(gainCut))
        else $error("gain cut not tracked");
    sel_chan_a: assert property (@(posedge core_clk) disable iff (!rstn)
        channelPm |=> selLevel == $past(peak_reg.pm)) else $error("wrong channel level");
    sel_am_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !channelPm |=> selLevel == $past(peak_reg.am)) else $error("wrong am level");
    // a write strobe without a read must leave the read data untouched
    write_ignored_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (wrEn && !rdEn) |=> $stable(rdData)) else $error("write changed read data");
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
/* directed testbench of the receiver status display registers.
   assumes rsd_pkg and rsd_status_regs are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rsd_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic core_clk, rstn, setDefaults, regSourceManual, measValid, msgStart;
    logic peakClear, channelPm, rdEn, wrEn;
    logic [3:0] regManualLevel, regAutoLevel, selLevel;
    logic [7:0] addr, rdData;
    rsd_timers_t timers;
    rsd_pair_t measLevel, gainCut;
    int miscompares = 0; // failed comparisons
    int checks = 0; // comparisons made
    rsd_status_regs uut (.core_clk(core_clk), .rstn(rstn), .setDefaults(setDefaults),
        .regSourceManual(regSourceManual), .regManualLevel(regManualLevel),
        .regAutoLevel(regAutoLevel), .timers(timers), .measValid(measValid),
        .measLevel(measLevel), .msgStart(msgStart), .peakClear(peakClear),
        .gainCut(gainCut), .channelPm(channelPm), .rdEn(rdEn), .wrEn(wrEn),
        .addr(addr), .rdData(rdData), .selLevel(selLevel));
    // ------------------------------------------------------------
    // clock, 8 ns period
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    // move n edges, inputs change 1 ns after each
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask
    // compare one byte result
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one read, one idle cycle after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rdEn = 1'b1;
        addr = a;
        tick(1);
        chk("rdData", exp, rdData);
        rdEn = 1'b0;
        tick(1);
    endtask
    // one-cycle peak sample
    task automatic meas(input logic [7:0] v);
        measValid = 1'b1;
        measLevel = v;
        tick(1);
        measValid = 1'b0;
        tick(1);
    endtask
    // verdict and end of run
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // watchdog, tests need about 62 cycles
    // ------------------------------------------------------------
    initial begin
        repeat (2000) @(posedge core_clk);
        miscompares++;
        close_out();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, setDefaults, regSourceManual, measValid, msgStart, peakClear} = '0;
        {channelPm, rdEn, wrEn, regManualLevel, regAutoLevel, addr} = '0;
        timers = '0;
        measLevel = '0;
        gainCut = '0;
        repeat (10) @(posedge core_clk);
        #1 rstn = 1'b1;
        rd(RSD_OFS_REG_TIMER, 8'hF0);
        rd(RSD_OFS_PEAKS, 8'h00);
        rd(RSD_OFS_GAIN, 8'h00);
        $display("test reset done");
        {regSourceManual, regManualLevel, regAutoLevel} = {1'b1, 4'hA, 4'h5};
        timers = 3'b101;
        tick(3);
        rd(RSD_OFS_REG_TIMER, 8'hA5);
        {regSourceManual, wrEn} = 2'b01;
        timers = 3'b010;
        tick(3);
        wrEn = 1'b0;
        rd(RSD_OFS_REG_TIMER, 8'h52);
        $display("test regulator done");
        meas(8'h37);
        meas(8'h29);
        meas(8'h51);
        channelPm = 1'b1;
        tick(2);
        chk("selLevel", 8'h09, {4'h0, selLevel});
        channelPm = 1'b0;
        tick(2);
        chk("selLevel", 8'h05, {4'h0, selLevel});
        rd(RSD_OFS_PEAKS, 8'h59);
        msgStart = 1'b1;
        meas(8'hFF);
        msgStart = 1'b0;
        rd(RSD_OFS_PEAKS, 8'h00);
        meas(8'hEE);
        peakClear = 1'b1;
        tick(1);
        peakClear = 1'b0;
        rd(RSD_OFS_PEAKS, 8'h00);
        $display("test peaks done");
        gainCut = 8'hC3;
        meas(8'h44);
        tick(2);
        rd(RSD_OFS_GAIN, 8'hC3);
        setDefaults = 1'b1;
        tick(1);
        setDefaults = 1'b0;
        rd(RSD_OFS_PEAKS, 8'h00);
        $display("test gain and defaults done");
        wrEn = 1'b1;
        rd(RSD_OFS_RSVD_A, 8'h00);
        wrEn = 1'b0;
        rd(RSD_OFS_RSVD_B, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reserved done");
        close_out();
    end
endmodule
`default_nettype wire
